//--- hdl/bir_pkg.sv
package bir_pkg;

  // Register port geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [15:0] OFF_NMI_STATUS_CONTROL   = 16'h0061;
  localparam logic [15:0] OFF_RESET_CAUSE          = 16'h3000;
  localparam logic [15:0] OFF_DEV_ICR_BASE         = 16'h0100;
  localparam logic [15:0] OFF_DEVICE_VECTOR_BASE   = 16'h0107;
  localparam logic [15:0] OFF_VME_ICR_BASE         = 16'h0110;
  localparam logic [15:0] OFF_DMA_DONE_INT_CONTROL = 16'h0120;
  localparam logic [15:0] OFF_ERROR_GROUP_INT_CTRL = 16'h0121;
  localparam logic [15:0] OFF_ACKED_INT_CONTROL    = 16'h0122;
  localparam logic [15:0] OFF_STATUS_EVENT_VBASE   = 16'h0123;
  localparam logic [15:0] OFF_MODULE_CONTROL       = 16'h0130;
  localparam logic [15:0] OFF_NMI_DELIVERY_ENABLE  = 16'h0131;
  localparam logic [15:0] OFF_SEC_MASK_LO          = 16'h0140;
  localparam logic [15:0] OFF_SEC_MASK_HI          = 16'h0141;
  localparam logic [15:0] OFF_SEC_VECTOR_BASE      = 16'h0150;

  // Field positions
  localparam int NMI_SERR_STS_BIT = 7;
  localparam int NMI_HALT_STS_BIT = 6;
  localparam int NMI_HALT_DIS_BIT = 3;
  localparam int NMI_SERR_DIS_BIT = 2;
  localparam int MODCTL_OPT_SEL_BIT = 1;
  localparam int MODCTL_WDOG_EN_BIT = 0;
  localparam int EG_DIS_LSB = 4;
  localparam int VBASE_LSB = 3;
  localparam int CAUSE_POWERUP_BIT = 0;
  localparam int CAUSE_SWITCH_BIT = 1;
  localparam int CAUSE_WDOG_BIT = 2;
  localparam int CAUSE_SYSRESET_BIT = 3;

  // Reset values
  localparam logic [2:0]  IPL_RESET    = 3'h0;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] SEC_MASK_RESET = 16'hffff;
  localparam logic [7:0]  CAUSE_RESET  = 8'h01;

  // Fixed ranks of the primary controller
  localparam logic [4:0] RANK_ACKED   = 5'h01;
  localparam logic [4:0] RANK_DMA     = 5'h02;
  localparam logic [4:0] RANK_VME_LO  = 5'h03;
  localparam logic [4:0] RANK_VME_HI  = 5'h09;
  localparam logic [4:0] RANK_DEV_LO  = 5'h0c;
  localparam logic [4:0] RANK_EGROUP  = 5'h12;
  localparam logic [4:0] RANK_DEV_ERR = 5'h13;

  // Low vector bits of the status events
  localparam logic [2:0] CODE_ACKED = 3'h0;
  localparam logic [2:0] CODE_DMA   = 3'h1;
  localparam logic [2:0] CODE_EG_LO = 3'h2;

  typedef enum logic [0:0] {ACK_IDLE, ACK_VME_WAIT} bir_ack_state_t;

endpackage

//--- hdl/bir_vec_mem.sv
module bir_vec_mem
  import bir_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem [0:DEPTH-1];
  logic [7:0] rd_data_r;

  // Vector table storage
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= BYTE_RESET;
    end else begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;

endmodule

//--- hdl/bir_int_router.sv
module bir_int_router
  import bir_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              ARST_N,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [7:0]        REG_WDATA,
  output logic      [7:0]        REG_RDATA,
  input  wire logic [6:0]        DEV_IRQ,
  input  wire logic [7:1]        VME_IRQ,
  input  wire logic [2:0]        OPT_IRQ,
  input  wire logic              SYS_CTRL,
  input  wire logic              SYSFAIL_EVT,
  input  wire logic              ACFAIL_EVT,
  input  wire logic              ARB_TIMEOUT_EVT,
  input  wire logic              WPOST_FAIL_EVT,
  input  wire logic              DMA_DONE_EVT,
  input  wire logic              OWN_IACKED_EVT,
  input  wire logic              ACK_RD,
  output logic      [10:0]       ACK_DATA,
  output logic                   ACK_VALID,
  output logic                   CPU_IRQ2,
  output logic      [2:0]        CPU_IPL,
  output logic                   VME_IACK_REQ,
  output logic      [2:0]        VME_IACK_LEVEL,
  input  wire logic              VME_IACK_DONE,
  input  wire logic [7:0]        VME_IACK_VECTOR,
  input  wire logic              SEC_ACK_RD,
  output logic      [7:0]        SEC_ACK_DATA,
  output logic                   SEC_ACK_VALID,
  output logic                   CPU_IRQ1,
  input  wire logic              PCI_SERR,
  input  wire logic              HALT_SW,
  input  wire logic              WDOG_EXPIRE,
  output logic                   CPU_IRQ0,
  input  wire logic              RESET_SW,
  input  wire logic              WDOG_TIMEOUT,
  input  wire logic              SYSRESET_N,
  input  wire logic              SYSRESET_SW_CLOSED,
  output logic                   MOD_RESET
);

  // Winner search: highest level, ties to highest rank
  function automatic logic [8:0] pick_winner(input logic [19:0] pend, input logic [59:0] lvl);
    logic [2:0] best;
    logic [4:0] rank;
    logic       found;
    best  = 3'h0;
    rank  = 5'h00;
    found = 1'b0;
    for (int r = 1; r < 20; r++) begin
      if (pend[r] && lvl[3*r +: 3] != 3'h0 && lvl[3*r +: 3] >= best) begin
        best  = lvl[3*r +: 3];
        rank  = 5'(r);
        found = 1'b1;
      end
    end
    return {found, rank, best};
  endfunction

  // Cascaded fixed order: 0, 1, slave 8..15, then 3..7
  function automatic logic [4:0] pick_sec(input logic [15:0] req);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 7; i > 2; i--) begin
      if (req[i]) res = {1'b1, 4'(i)};
    end
    for (int i = 15; i > 7; i--) begin
      if (req[i]) res = {1'b1, 4'(i)};
    end
    for (int i = 1; i >= 0; i--) begin
      if (req[i]) res = {1'b1, 4'(i)};
    end
    return res;
  endfunction

  logic [2:0]     dev_ipl_r [0:6];
  logic [2:0]     vme_ipl_r [1:7];
  logic [7:3]     dev_vbase_r;
  logic [7:3]     sts_vbase_r;
  logic [2:0]     dma_ipl_r;
  logic [2:0]     acked_ipl_r;
  logic [7:0]     egicr_r;
  logic [7:0]     modctl_r;
  logic           nmi_en_r;
  logic [15:0]    sec_mask_r;
  logic [3:0]     eg_flag_r;
  logic           dma_flag_r;
  logic           acked_flag_r;
  logic           serr_sts_r;
  logic           halt_sts_r;
  logic           serr_dis_r;
  logic           halt_dis_r;
  logic [7:0]     cause_r;
  logic           mod_rst_r;
  logic           vic_rst_r;
  logic           sysrst_latch_r;
  bir_ack_state_t ack_state_r;
  logic [2:0]     ack_ipl_r;
  logic           sec_rd_d1_r;
  logic           sec_none_r;
  logic           sec_was8_r;
  logic [19:0]    pend;
  logic [59:0]    lvl;
  logic [8:0]     win;
  logic           win_found;
  logic [4:0]     win_rank;
  logic [2:0]     win_ipl;
  logic [3:0]     eg_live;
  logic [2:0]     eg_code;
  logic           ack_take;
  logic [15:0]    sec_in;
  logic [4:0]     sec_win;
  logic [7:0]     sec_rdata;
  logic           ctrl_rst;
  logic           sec_vec_wr;
  logic           mod_evt;

  assign mod_evt  = RESET_SW | WDOG_TIMEOUT | (!SYSRESET_N & SYSRESET_SW_CLOSED);
  assign ctrl_rst = mod_rst_r | vic_rst_r;

  // Reset request capture
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mod_rst_r <= 1'b0;
      vic_rst_r <= 1'b0;
    end else begin
      mod_rst_r <= mod_evt;
      vic_rst_r <= !SYSRESET_N & !SYSRESET_SW_CLOSED;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cause_r <= CAUSE_RESET;
    end else if (mod_evt && !mod_rst_r) begin
      cause_r <= BYTE_RESET;
      cause_r[CAUSE_SWITCH_BIT]   <= RESET_SW;
      cause_r[CAUSE_WDOG_BIT]     <= WDOG_TIMEOUT;
      cause_r[CAUSE_SYSRESET_BIT] <= !SYSRESET_N & SYSRESET_SW_CLOSED;
    end
  end

  // Controller configuration registers
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 7; i++) dev_ipl_r[i] <= IPL_RESET;
      for (int i = 1; i < 8; i++) vme_ipl_r[i] <= IPL_RESET;
      dev_vbase_r <= BYTE_RESET[7:3];
      sts_vbase_r <= BYTE_RESET[7:3];
      dma_ipl_r   <= IPL_RESET;
      acked_ipl_r <= IPL_RESET;
      egicr_r     <= BYTE_RESET;
    end else if (ctrl_rst) begin
      for (int i = 0; i < 7; i++) dev_ipl_r[i] <= IPL_RESET;
      for (int i = 1; i < 8; i++) vme_ipl_r[i] <= IPL_RESET;
      dev_vbase_r <= BYTE_RESET[7:3];
      sts_vbase_r <= BYTE_RESET[7:3];
      dma_ipl_r   <= IPL_RESET;
      acked_ipl_r <= IPL_RESET;
      egicr_r     <= BYTE_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR >= OFF_DEV_ICR_BASE && REG_ADDR < OFF_DEVICE_VECTOR_BASE) begin
        dev_ipl_r[3'(REG_ADDR - OFF_DEV_ICR_BASE)] <= REG_WDATA[2:0];
      end else if (REG_ADDR == OFF_DEVICE_VECTOR_BASE) begin
        dev_vbase_r <= REG_WDATA[7:VBASE_LSB];
      end else if (REG_ADDR > OFF_VME_ICR_BASE && REG_ADDR < OFF_VME_ICR_BASE + 16'h0008) begin
        vme_ipl_r[3'(REG_ADDR - OFF_VME_ICR_BASE)] <= REG_WDATA[2:0];
      end else if (REG_ADDR == OFF_DMA_DONE_INT_CONTROL) begin
        dma_ipl_r <= REG_WDATA[2:0];
      end else if (REG_ADDR == OFF_ERROR_GROUP_INT_CTRL) begin
        egicr_r <= REG_WDATA;
      end else if (REG_ADDR == OFF_ACKED_INT_CONTROL) begin
        acked_ipl_r <= REG_WDATA[2:0];
      end else if (REG_ADDR == OFF_STATUS_EVENT_VBASE) begin
        sts_vbase_r <= REG_WDATA[7:VBASE_LSB];
      end
    end
  end

  // Module-level registers, cleared by module reset
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      modctl_r   <= BYTE_RESET;
      nmi_en_r   <= 1'b0;
      sec_mask_r <= SEC_MASK_RESET;
      serr_dis_r <= 1'b0;
      halt_dis_r <= 1'b0;
    end else if (mod_rst_r) begin
      modctl_r   <= BYTE_RESET;
      nmi_en_r   <= 1'b0;
      sec_mask_r <= SEC_MASK_RESET;
      serr_dis_r <= 1'b0;
      halt_dis_r <= 1'b0;
    end else if (REG_WR) begin
      if (REG_ADDR == OFF_MODULE_CONTROL) begin
        modctl_r <= REG_WDATA;
      end else if (REG_ADDR == OFF_NMI_DELIVERY_ENABLE) begin
        nmi_en_r <= REG_WDATA[0];
      end else if (REG_ADDR == OFF_SEC_MASK_LO) begin
        sec_mask_r[7:0] <= REG_WDATA;
      end else if (REG_ADDR == OFF_SEC_MASK_HI) begin
        sec_mask_r[15:8] <= REG_WDATA;
      // Only the two disable bits are stored
      end else if (REG_ADDR == OFF_NMI_STATUS_CONTROL) begin
        serr_dis_r <= REG_WDATA[NMI_SERR_DIS_BIT];
        halt_dis_r <= REG_WDATA[NMI_HALT_DIS_BIT];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      serr_sts_r <= 1'b0;
    end else if (mod_rst_r || serr_dis_r) begin
      serr_sts_r <= 1'b0;
    end else if (PCI_SERR) begin
      serr_sts_r <= 1'b1;
    end
  end

  // Halt status from switch or enabled watchdog
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      halt_sts_r <= 1'b0;
    end else if (mod_rst_r || halt_dis_r) begin
      halt_sts_r <= 1'b0;
    end else if (HALT_SW || (WDOG_EXPIRE && modctl_r[MODCTL_WDOG_EN_BIT])) begin
      halt_sts_r <= 1'b1;
    end
  end

  // Nonmaskable output gated by delivery enable
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CPU_IRQ0 <= 1'b0;
    end else begin
      CPU_IRQ0 <= nmi_en_r & (serr_sts_r | halt_sts_r);
    end
  end

  // Error group flags behind individual disables
  assign eg_live = eg_flag_r & ~egicr_r[EG_DIS_LSB +: 4];

  // Primary request vector, indexed by rank
  always_comb begin
    pend = 20'h00000;
    lvl  = 60'h0;
    pend[RANK_ACKED] = acked_flag_r;
    lvl[3*RANK_ACKED +: 3] = acked_ipl_r;
    pend[RANK_DMA] = dma_flag_r;
    lvl[3*RANK_DMA +: 3] = dma_ipl_r;
    // VME lines only as system controller
    for (int i = 1; i < 8; i++) begin
      pend[int'(RANK_VME_LO) + i - 1] = VME_IRQ[i] & SYS_CTRL;
      lvl[3*(int'(RANK_VME_LO) + i - 1) +: 3] = vme_ipl_r[i];
    end
    for (int i = 0; i < 6; i++) begin
      pend[int'(RANK_DEV_LO) + i] = DEV_IRQ[i];
      lvl[3*(int'(RANK_DEV_LO) + i) +: 3] = dev_ipl_r[i];
    end
    pend[RANK_DEV_ERR] = DEV_IRQ[6];
    lvl[3*RANK_DEV_ERR +: 3] = dev_ipl_r[6];
    pend[RANK_EGROUP] = |eg_live;
    lvl[3*RANK_EGROUP +: 3] = egicr_r[2:0];
  end

  assign win       = pick_winner(pend, lvl);
  assign win_found = win[8];
  assign win_rank  = win[7:3];
  assign win_ipl   = win[2:0];
  assign ack_take  = (ack_state_r == ACK_IDLE) && ACK_RD && win_found;

  // Lowest pending error group condition
  always_comb begin
    eg_code = CODE_EG_LO;
    for (int i = 3; i >= 0; i--) begin
      if (eg_live[i]) eg_code = CODE_EG_LO + 3'(i);
    end
  end

  // Sticky status events; a new event beats its clear
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      eg_flag_r    <= 4'h0;
      dma_flag_r   <= 1'b0;
      acked_flag_r <= 1'b0;
    end else if (ctrl_rst) begin
      eg_flag_r    <= 4'h0;
      dma_flag_r   <= 1'b0;
      acked_flag_r <= 1'b0;
    end else begin
      if (ack_take && win_rank == RANK_EGROUP) begin
        eg_flag_r[2'(eg_code - CODE_EG_LO)] <= 1'b0;
      end
      if (SYSFAIL_EVT) eg_flag_r[0] <= 1'b1;
      if (ACFAIL_EVT) eg_flag_r[1] <= 1'b1;
      if (ARB_TIMEOUT_EVT) eg_flag_r[2] <= 1'b1;
      if (WPOST_FAIL_EVT) eg_flag_r[3] <= 1'b1;
      dma_flag_r   <= DMA_DONE_EVT | (dma_flag_r & !(ack_take && win_rank == RANK_DMA));
      acked_flag_r <= OWN_IACKED_EVT |
                      (acked_flag_r & !(ack_take && win_rank == RANK_ACKED));
    end
  end

  // Primary request pins
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CPU_IRQ2 <= 1'b0;
      CPU_IPL  <= IPL_RESET;
    end else begin
      CPU_IRQ2 <= win_found;
      CPU_IPL  <= win_ipl;
    end
  end

  // Acknowledge read sequencer
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_state_r    <= ACK_IDLE;
      ack_ipl_r      <= IPL_RESET;
      ACK_DATA       <= 11'h000;
      ACK_VALID      <= 1'b0;
      VME_IACK_REQ   <= 1'b0;
      VME_IACK_LEVEL <= 3'h0;
    end else if (ctrl_rst) begin
      ack_state_r  <= ACK_IDLE;
      ACK_VALID    <= 1'b0;
      VME_IACK_REQ <= 1'b0;
    end else begin
      ACK_VALID <= 1'b0;
      case (ack_state_r)
        ACK_IDLE: begin
          if (ACK_RD) begin
            if (!win_found) begin
              ACK_DATA  <= 11'h000;
              ACK_VALID <= 1'b1;
            end else if (win_rank >= RANK_VME_LO && win_rank <= RANK_VME_HI) begin
              // Start bus IACK for the line
              ack_state_r    <= ACK_VME_WAIT;
              ack_ipl_r      <= win_ipl;
              VME_IACK_REQ   <= 1'b1;
              VME_IACK_LEVEL <= 3'(win_rank - RANK_VME_LO + 5'h01);
            end else if (win_rank >= RANK_DEV_LO && win_rank != RANK_EGROUP) begin
              ACK_DATA  <= {win_ipl, dev_vbase_r,
                            (win_rank == RANK_DEV_ERR) ? 3'h6 : 3'(win_rank - RANK_DEV_LO)};
              ACK_VALID <= 1'b1;
            end else begin
              ACK_DATA  <= {win_ipl, sts_vbase_r,
                            (win_rank == RANK_ACKED) ? CODE_ACKED :
                            (win_rank == RANK_DMA) ? CODE_DMA : eg_code};
              ACK_VALID <= 1'b1;
            end
          end
        end
        ACK_VME_WAIT: begin
          if (VME_IACK_DONE) begin
            ACK_DATA     <= {ack_ipl_r, VME_IACK_VECTOR};
            ACK_VALID    <= 1'b1;
            VME_IACK_REQ <= 1'b0;
            ack_state_r  <= ACK_IDLE;
          end
        end
        default: ack_state_r <= ACK_IDLE;
      endcase
    end
  end

  // SYSRESET seen on secondary input eight
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sysrst_latch_r <= 1'b0;
    end else if (!SYSRESET_N) begin
      sysrst_latch_r <= 1'b1;
    end else if (sec_rd_d1_r && sec_was8_r) begin
      sysrst_latch_r <= 1'b0;
    end
  end

  always_comb begin
    sec_in = 16'h0000;
    sec_in[7:4] = VME_IRQ[7:4];
    sec_in[3:1] = modctl_r[MODCTL_OPT_SEL_BIT] ? OPT_IRQ : VME_IRQ[3:1];
    sec_in[8]   = sysrst_latch_r;
  end

  assign sec_win    = pick_sec(sec_in & ~sec_mask_r);
  assign sec_vec_wr = REG_WR && REG_ADDR >= OFF_SEC_VECTOR_BASE &&
                      REG_ADDR < OFF_SEC_VECTOR_BASE + 16'h0010;

  // Local vector table, no bus cycle
  bir_vec_mem #(
    .DEPTH (16),
    .AW    (4)
  ) u_vec_mem (
    .clk     (SYS_CLK),
    .arst_n  (ARST_N),
    .wr_en   (sec_vec_wr),
    .wr_addr (4'(REG_ADDR - OFF_SEC_VECTOR_BASE)),
    .wr_data (REG_WDATA),
    .rd_addr (sec_win[3:0]),
    .rd_data (sec_rdata)
  );

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CPU_IRQ1      <= 1'b0;
      sec_rd_d1_r   <= 1'b0;
      sec_none_r    <= 1'b0;
      sec_was8_r    <= 1'b0;
      SEC_ACK_DATA  <= BYTE_RESET;
      SEC_ACK_VALID <= 1'b0;
    end else begin
      CPU_IRQ1      <= sec_win[4];
      sec_rd_d1_r   <= SEC_ACK_RD;
      sec_none_r    <= !sec_win[4];
      sec_was8_r    <= sec_win[4] && sec_win[3:0] == 4'h8;
      SEC_ACK_VALID <= sec_rd_d1_r;
      if (sec_rd_d1_r) begin
        SEC_ACK_DATA <= sec_none_r ? BYTE_RESET : sec_rdata;
      end
    end
  end

  // Register read port
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= BYTE_RESET;
    end else if (REG_RD) begin
      if (REG_ADDR == OFF_NMI_STATUS_CONTROL) begin
        REG_RDATA <= {serr_sts_r, halt_sts_r, 2'b00, halt_dis_r, serr_dis_r, 2'b00};
      end else if (REG_ADDR == OFF_RESET_CAUSE) begin
        REG_RDATA <= cause_r;
      end else if (REG_ADDR >= OFF_DEV_ICR_BASE && REG_ADDR < OFF_DEVICE_VECTOR_BASE) begin
        REG_RDATA <= {5'h00, dev_ipl_r[3'(REG_ADDR - OFF_DEV_ICR_BASE)]};
      end else if (REG_ADDR == OFF_DEVICE_VECTOR_BASE) begin
        REG_RDATA <= {dev_vbase_r, 3'h0};
      end else if (REG_ADDR > OFF_VME_ICR_BASE && REG_ADDR < OFF_VME_ICR_BASE + 16'h0008) begin
        REG_RDATA <= {5'h00, vme_ipl_r[3'(REG_ADDR - OFF_VME_ICR_BASE)]};
      end else if (REG_ADDR == OFF_DMA_DONE_INT_CONTROL) begin
        REG_RDATA <= {5'h00, dma_ipl_r};
      end else if (REG_ADDR == OFF_ERROR_GROUP_INT_CTRL) begin
        REG_RDATA <= egicr_r;
      end else if (REG_ADDR == OFF_ACKED_INT_CONTROL) begin
        REG_RDATA <= {5'h00, acked_ipl_r};
      end else if (REG_ADDR == OFF_STATUS_EVENT_VBASE) begin
        REG_RDATA <= {sts_vbase_r, 3'h0};
      end else if (REG_ADDR == OFF_MODULE_CONTROL) begin
        REG_RDATA <= modctl_r;
      end else if (REG_ADDR == OFF_NMI_DELIVERY_ENABLE) begin
        REG_RDATA <= {7'h00, nmi_en_r};
      end else if (REG_ADDR == OFF_SEC_MASK_LO) begin
        REG_RDATA <= sec_mask_r[7:0];
      end else if (REG_ADDR == OFF_SEC_MASK_HI) begin
        REG_RDATA <= sec_mask_r[15:8];
      end else begin
        REG_RDATA <= BYTE_RESET;
      end
    end
  end

  // Module reset indication
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MOD_RESET <= 1'b0;
    end else begin
      MOD_RESET <= mod_rst_r;
    end
  end

endmodule

//--- dv/bir_int_router_sva.sv
module bir_int_router_sva
  import bir_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        ARST_N,
  input wire logic        REG_WR,
  input wire logic        ACK_RD,
  input wire logic [10:0] ACK_DATA,
  input wire logic        ACK_VALID,
  input wire logic        VME_IACK_REQ,
  input wire logic        VME_IACK_DONE,
  input wire logic [7:0]  VME_IACK_VECTOR,
  input wire logic        SEC_ACK_RD,
  input wire logic        SEC_ACK_VALID,
  input wire logic        CPU_IRQ0,
  input wire logic        RESET_SW,
  input wire logic        MOD_RESET
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_seen_r;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // Any register write since power-up
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) wr_seen_r <= 1'b0;
    else if (REG_WR) wr_seen_r <= 1'b1;
  end
  chk_iack_cause: assert property ($rose(VME_IACK_REQ) |-> $past(ACK_RD))
    else $error("bus acknowledge without local read");
  chk_iack_end: assert property (
    VME_IACK_REQ && VME_IACK_DONE |=> ACK_VALID && !VME_IACK_REQ)
    else $error("bus acknowledge not closed");
  chk_iack_vec: assert property (
    VME_IACK_DONE && VME_IACK_REQ |=> ACK_DATA[7:0] == $past(VME_IACK_VECTOR))
    else $error("bus vector not passed on");
  chk_local_ack: assert property (
    ACK_RD && !VME_IACK_REQ |=> ACK_VALID || VME_IACK_REQ)
    else $error("acknowledge read unanswered");
  chk_empty_zero: assert property (
    ACK_VALID && ACK_DATA[10:8] == 3'h0 |-> ACK_DATA[7:0] == 8'h00)
    else $error("vector without level is not zero");
  chk_nmi_off: assert property (!wr_seen_r |-> !CPU_IRQ0)
    else $error("nonmaskable line before enable");
  chk_sec_answer: assert property (SEC_ACK_RD |-> ##2 SEC_ACK_VALID)
    else $error("secondary acknowledge late");
  chk_mod_reset: assert property ($rose(RESET_SW) |-> ##[1:3] MOD_RESET)
    else $error("switch reset not applied");
endmodule

//--- dv/bir_vme_partner.sv
module bir_vme_partner (
  input  wire logic       clk,
  input  wire logic [7:1] raise,
  input  wire logic       req,
  input  wire logic [2:0] level,
  output logic      [7:1] irq,
  output logic            done,
  output logic      [7:0] vector
);
  timeunit 1ns;
  timeprecision 1ns;
  int   wait_n = 0;
  logic slow   = 1'b0;
  initial {irq, done, vector} = 16'h005a;
  // Interrupter answering bus acknowledge, promptly then slowly
  always @(posedge clk) begin
    irq <= irq | raise;
    done <= 1'b0;
    vector <= ~vector;
    if (req && !done) wait_n <= wait_n + 1;
    if (req && !done && wait_n == (slow ? 5 : 1)) begin
      irq[level] <= 1'b0;
      done <= 1'b1;
      vector <= 8'ha0 | 8'(level);
      wait_n <= 0;
      slow <= !slow;
    end
  end
endmodule

//--- dv/bir_int_router_tb.sv
module bir_int_router_tb;
  import bir_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        SYS_CLK, ARST_N, REG_WR, REG_RD, ACK_RD, SEC_ACK_RD, SYS_CTRL, PCI_SERR;
  logic        HALT_SW, RESET_SW, SYSRESET_N, ACK_VALID, CPU_IRQ2, VME_IACK_REQ, VME_IACK_DONE;
  logic        SEC_ACK_VALID, CPU_IRQ1, CPU_IRQ0, MOD_RESET, rd_d, WDOG_EXPIRE, WDOG_TIMEOUT;
  logic        SYSRESET_SW_CLOSED;
  logic [15:0] REG_ADDR;
  logic [10:0] ACK_DATA;
  logic [7:0]  REG_WDATA, REG_RDATA, SEC_ACK_DATA, VME_IACK_VECTOR, b;
  logic [7:1]  VME_IRQ, raise;
  logic [6:0]  DEV_IRQ;
  logic [5:0]  evt;
  logic [2:0]  CPU_IPL, VME_IACK_LEVEL, OPT_IRQ, lvl;
  logic [10:0] exp_q[$];
  logic [31:0] seed = 32'h64dd41b0;
  int          mismatches = 0;
  int          checks_done = 0;
  bir_int_router dut (.*, .SYSFAIL_EVT(evt[2]), .ACFAIL_EVT(evt[3]), .ARB_TIMEOUT_EVT(evt[4]),
    .WPOST_FAIL_EVT(evt[5]), .DMA_DONE_EVT(evt[1]), .OWN_IACKED_EVT(evt[0]));
  bir_vme_partner vme (.clk(SYS_CLK), .raise(raise), .req(VME_IACK_REQ),
    .level(VME_IACK_LEVEL), .irq(VME_IRQ), .done(VME_IACK_DONE), .vector(VME_IACK_VECTOR));
  // Clock
  initial begin
    SYS_CLK = 0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [10:0] seen, logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
    if (!w) exp_q.push_back({3'h0, d});
    @(negedge SYS_CLK);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
    @(negedge SYS_CLK);
    {REG_WR, REG_RD} = 2'b00;
    @(negedge SYS_CLK);
  endtask
  task automatic ack(logic s, logic [10:0] e);
    exp_q.push_back(e);
    repeat (3) @(negedge SYS_CLK);
    {SEC_ACK_RD, ACK_RD} = {s, !s};
    @(negedge SYS_CLK);
    {SEC_ACK_RD, ACK_RD} = 2'b00;
    for (int n = 0; n < 40 && (s ? SEC_ACK_VALID : ACK_VALID) !== 1'b1; n++) @(negedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Oldest note against each answer
  always @(posedge SYS_CLK) rd_d <= REG_RD;
  always @(negedge SYS_CLK) begin
    if (ACK_VALID === 1'b1) chk("ack", ACK_DATA, exp_q.pop_front());
    if (rd_d === 1'b1) chk("reg", {3'h0, REG_RDATA}, exp_q.pop_front());
    if (SEC_ACK_VALID === 1'b1) chk("sec", {3'h0, SEC_ACK_DATA}, exp_q.pop_front());
  end
  // Watchdog, about eight times the expected run
  initial begin
    #300000;
    mismatches++;
    results();
  end
  // Main sequence
  initial begin
    {REG_WR, REG_RD, ACK_RD, SEC_ACK_RD, SYS_CTRL, PCI_SERR, HALT_SW, RESET_SW} = '0;
    {ARST_N, WDOG_EXPIRE, WDOG_TIMEOUT, SYSRESET_SW_CLOSED, OPT_IRQ} = '0;
    {REG_ADDR, REG_WDATA, raise, DEV_IRQ, evt} = '0;
    SYSRESET_N = 1;
    repeat (20) @(negedge SYS_CLK);
    ARST_N = 1;
    bus(0, OFF_NMI_STATUS_CONTROL, 8'h00);
    bus(0, OFF_RESET_CAUSE, CAUSE_RESET);
    bus(0, 16'h0200, 8'h00);
    $display("reset test done");
    b = 8'(rnd());
    bus(1, OFF_DEVICE_VECTOR_BASE, b);
    for (int i = 0; i < 7; i++) begin
      lvl = 3'(rnd() % 7 + 1);
      bus(1, OFF_DEV_ICR_BASE + 16'(i), {5'h00, lvl});
      DEV_IRQ[i] = 1;
      @(negedge SYS_CLK);
      chk("ipl", {7'h00, CPU_IRQ2, CPU_IPL}, {8'h01, lvl});
      ack(0, {lvl, b[7:3], 3'(i)});
      DEV_IRQ[i] = 0;
      bus(1, OFF_DEV_ICR_BASE + 16'(i), 8'h00);
    end
    bus(1, OFF_DEV_ICR_BASE, 8'h03);
    bus(1, OFF_DEV_ICR_BASE + 16'h6, 8'h03);
    DEV_IRQ = 7'h41;
    ack(0, {3'h3, b[7:3], 3'h6});
    bus(1, OFF_DEV_ICR_BASE, 8'h00);
    bus(1, OFF_DEV_ICR_BASE + 16'h6, 8'h00);
    DEV_IRQ = 7'h7f;
    ack(0, 11'h000);
    DEV_IRQ = 0;
    $display("device test done");
    bus(1, OFF_STATUS_EVENT_VBASE, b);
    for (int k = 0; k < 6; k++) begin
      lvl = 3'(rnd() % 7 + 1);
      bus(1, k == 0 ? OFF_ACKED_INT_CONTROL : k == 1 ? OFF_DMA_DONE_INT_CONTROL
        : OFF_ERROR_GROUP_INT_CTRL, {5'h00, lvl});
      evt[k] = 1;
      @(negedge SYS_CLK);
      evt = 0;
      ack(0, {lvl, b[7:3], 3'(k)});
    end
    bus(1, OFF_ERROR_GROUP_INT_CTRL, 8'hf7);
    evt = 6'h3c;
    @(negedge SYS_CLK);
    evt = 0;
    ack(0, 11'h000);
    $display("status event test done");
    SYS_CTRL = 1;
    bus(1, OFF_VME_ICR_BASE + 16'h5, 8'h07);
    for (int r = 0; r < 2; r++) begin
      raise = 7'h10;
      @(negedge SYS_CLK);
      raise = 0;
      ack(0, {3'h7, 8'ha5});
    end
    $display("bus acknowledge test done");
    bus(1, OFF_NMI_DELIVERY_ENABLE, 8'h01);
    bus(1, OFF_MODULE_CONTROL, 8'h01);
    for (int e = 0; e < 3; e++) begin
      {WDOG_EXPIRE, HALT_SW, PCI_SERR} = 3'(1 << e);
      @(negedge SYS_CLK);
      {WDOG_EXPIRE, HALT_SW, PCI_SERR} = 3'b000;
      bus(0, OFF_NMI_STATUS_CONTROL, e ? 8'h40 : 8'h80);
      chk("nmi", {10'h000, CPU_IRQ0}, 11'h001);
      bus(0, OFF_RESET_CAUSE, CAUSE_RESET);
      bus(1, OFF_NMI_STATUS_CONTROL, 8'h0c);
      bus(1, OFF_NMI_STATUS_CONTROL, 8'h00);
      bus(0, OFF_NMI_STATUS_CONTROL, 8'h00);
    end
    $display("nonmaskable test done");
    bus(1, OFF_SEC_MASK_HI, 8'hfe);
    bus(1, OFF_SEC_VECTOR_BASE + 16'h8, 8'h5a);
    SYSRESET_N = 0;
    @(negedge SYS_CLK);
    SYSRESET_N = 1;
    @(negedge SYS_CLK);
    chk("irq1", {10'h000, CPU_IRQ1}, 11'h001);
    ack(1, 11'h05a);
    bus(1, OFF_MODULE_CONTROL, 8'h02);
    bus(1, OFF_SEC_MASK_LO, 8'h00);
    bus(1, OFF_SEC_VECTOR_BASE + 16'h3, b);
    raise = 7'h04;
    @(negedge SYS_CLK);
    raise = 0;
    ack(1, 11'h000);
    OPT_IRQ = 3'h4;
    ack(1, {3'h0, b});
    OPT_IRQ = 0;
    SYSRESET_SW_CLOSED = 1;
    for (int m = 1; m < 4; m++) begin
      {SYSRESET_N, WDOG_TIMEOUT, RESET_SW} = {m != 3, m == 2, m == 1};
      repeat (3) @(negedge SYS_CLK);
      {SYSRESET_N, WDOG_TIMEOUT, RESET_SW} = 3'b100;
      repeat (4) @(negedge SYS_CLK);
      bus(0, OFF_RESET_CAUSE, 8'(1 << m));
    end
    bus(0, OFF_NMI_DELIVERY_ENABLE, 8'h00);
    $display("reset source test done");
    results();
  end
endmodule
bind bir_int_router bir_int_router_sva chk (.*);
